// [test/icr_config_regs_assertions.sv]
// Port checker for the configuration bank.
`timescale 1ns/1ps
`default_nettype none
module icr_config_regs_assertions
(
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_waddr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_raddr,
    input wire logic [31:0] reg_rdata_q,
    input wire logic        reg_rvalid_q,
    input wire logic [31:0] capture_src,
    input wire logic [31:0] capture_hold_q,
    input wire logic        capture_done_q,
    input wire logic        timer_expire_q,
    input wire logic        timer_active_q,
    input wire logic [2:0]  min_edge_interval_q,
    input wire logic [2:0]  zero_pulse_incr_q,
    input wire logic [3:0]  interp_rate_q,
    input wire logic        gain_loop_run_q
);
    // One clock domain; decoded outputs trail a write by two edges.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////
    a_read_answer: assert property (reg_rd |=> reg_rvalid_q)
        else $error("read not answered");
    a_aux_reserved: assert property (reg_rd && reg_raddr == 8'h10 |=>
        reg_rdata_q[31] == 1'b0 && reg_rdata_q[23:21] == 3'h0) else $error("reserved set");
    a_hold_loaded: assert property (capture_done_q |-> capture_hold_q == $past(capture_src))
        else $error("hold mismatch");
    a_zpw_width: assert property (zero_pulse_incr_q inside {3'h1, 3'h4})
        else $error("bad index width");
    a_timer_quiet: assert property (!timer_active_q && !$past(timer_active_q) |->
        !timer_expire_q) else $error("idle timer fired");
    a_rate_follows: assert property (reg_wr && reg_waddr == 8'h00 |->
        ##2 interp_rate_q == $past(reg_wdata[3:0], 2)) else $error("rate stale");
    a_edge_msb: assert property (reg_wr && reg_waddr == 8'h01 |->
        ##2 min_edge_interval_q[2] == $past(reg_wdata[2], 2)) else $error("msb stale");
    a_loop_disable: assert property (reg_wr && reg_waddr == 8'h12 |->
        ##2 gain_loop_run_q == !$past(reg_wdata[0], 2)) else $error("loop state");
    c_read: cover property (reg_rvalid_q);
    c_capture: cover property (capture_done_q);
    c_timer: cover property (timer_expire_q);
endmodule // icr_config_regs_assertions
bind icr_config_regs icr_config_regs_assertions u_chk
(
    .mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_raddr(reg_raddr), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .capture_src(capture_src), .capture_hold_q(capture_hold_q),
    .capture_done_q(capture_done_q), .timer_expire_q(timer_expire_q),
    .timer_active_q(timer_active_q), .min_edge_interval_q(min_edge_interval_q),
    .zero_pulse_incr_q(zero_pulse_incr_q), .interp_rate_q(interp_rate_q),
    .gain_loop_run_q(gain_loop_run_q)
);
`default_nettype wire

// [test/icr_config_regs_tb.sv]
// Self-checking bench for the configuration bank.
`timescale 1ns/1ps
`default_nettype none
module icr_config_regs_tb;
    logic        mclk = 1'b0, rstn = 1'b0, cmd = 1'b0, tick = 1'b0;
    logic [31:0] src = 32'h0, rdata, hold, v;
    logic        wr, rd, rvalid, done, t_exp, t_act, ph_r, g_run, o_run;
    logic [7:0]  waddr, wdata, raddr;
    logic [2:0]  mei, zpw;
    logic [3:0]  rate;
    logic [1:0]  gset, oset;
    logic [5:0]  ph_v;
    // Strap levels and prescaler ticks stay under bench control.
    logic [3:0]  s_rate = 4'hA, ptick = 4'hF;
    logic [1:0]  s_mode = 2'h1, s_tpp = 2'h2, s_gain = 2'h1;
    logic        s_zpw = 1'b1, s_ref = 1'b0, s_filt = 1'b0;
    int          error_cnt = 0, checks = 0;
    // 250 MHz clock.
    always #2 mclk = ~mclk;
    icr_config_regs u_dut
    (
        .mclk(mclk), .rstn(rstn), .reg_wr(wr), .reg_waddr(waddr), .reg_wdata(wdata),
        .reg_rd(rd), .reg_raddr(raddr), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
        .strap_rate(s_rate), .strap_zpw(s_zpw), .strap_refdis(s_ref), .strap_mode(s_mode),
        .strap_tpp(s_tpp), .strap_filt(s_filt), .strap_gain(s_gain), .capture_cmd(cmd),
        .sample_tick(tick), .capture_src(src), .capture_hold_q(hold), .capture_done_q(done),
        .prescale_tick(ptick), .timer_expire_q(t_exp), .timer_active_q(t_act),
        .min_edge_interval_q(mei), .zero_pulse_incr_q(zpw), .interp_rate_q(rate),
        .gain_loop_run_q(g_run), .offset_loop_run_q(o_run), .amplitude_loop_settle_sel_q(gset),
        .offset_loop_settle_sel_q(oset), .phase_trim_value_q(ph_v), .phase_trim_range_sel_q(ph_r)
    );
    icr_host_model u_host
    (
        .mclk(mclk), .reg_rdata_q(rdata), .reg_wr(wr), .reg_waddr(waddr), .reg_wdata(wdata),
        .reg_rd(rd), .reg_raddr(raddr)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        u_host.rd(a, v);
        chk(v, exp);
        chk({31'h0, rvalid}, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////
    // Straps merged after reset release; main value 007F425A follows from the strap levels.
    task automatic t_reset;
        rdc(8'h00, 32'h007F425A);
        rdc(8'h10, 32'h0);
        chk({rate, zpw, g_run, o_run}, 9'h153);
    endtask
    // All-ones aux write; reserved bits drop, loops stop; unmapped places ignored.
    task automatic t_aux;
        u_host.wr32(8'h10, 32'hFFFFFFFF);
        rdc(8'h10, 32'h7F1FFFFF);
        chk({ph_r, ph_v, gset, oset, g_run, o_run}, 13'h1FFC);
        u_host.wr(8'h20, 8'hFF);
        u_host.wr(8'h04, 8'hFF);
        rdc(8'h20, 32'h0);
        rdc(8'h00, 32'h007F425A);
        u_host.wr32(8'h10, 32'h0);
    endtask
    // Rate, narrow index and edge-interval MSB, then both error setups.
    task automatic t_main;
        u_host.wr(8'h00, 8'h05);
        u_host.wr(8'h01, 8'h04);
        u_host.set_modes(1'b1);
        rdc(8'h00, 32'h407F0405);
        chk({mei, zpw, rate}, 10'h215);
        u_host.set_modes(1'b0);
        rdc(8'h00, 32'h77770405);
    endtask
    // One capture; counts falling edges until the hold reports.
    task automatic cap(input logic tk, input int want);
        int n = 0;
        @(negedge mclk);
        src = src + 32'h9E3779B9;
        cmd = 1'b1;
        @(negedge mclk);
        cmd = 1'b0;
        tick = tk;
        while (done !== 1'b1 && n < 40)
        begin
            @(negedge mclk);
            tick = 1'b0;
            n++;
        end
        tick = 1'b0;
        chk(n, want);
        chk(hold, src);
    endtask
    // Immediate capture is seen at once despite an offset of 4; sync capture lands offset
    // plus one cycles after the tick edge, which this loop counts as offset plus two.
    task automatic t_capture;
        u_host.wr(8'h11, 8'h90);
        cap(1'b1, 0);
        u_host.wr(8'h11, 8'h10);
        cap(1'b1, 6);
    endtask
    // Period T+1 with a tick every cycle, then silence once disabled.
    task automatic t_timer;
        int   n = 0;
        logic seen = 1'b0;
        u_host.wr(8'h10, 8'h03);
        u_host.wr(8'h11, 8'h01);
        while (t_exp !== 1'b1 && n < 50)
        begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        n = 1;
        while (t_exp !== 1'b1 && n < 50)
        begin
            @(negedge mclk);
            n++;
        end
        chk(n, 4);
        // With the selected prescaler silent the timer stays enabled but never fires.
        ptick = 4'h1;
        repeat (20)
        begin
            @(negedge mclk);
            seen = seen | t_exp;
        end
        chk({t_act, seen}, 2'h2);
        seen = 1'b0;
        ptick = 4'hF;
        u_host.wr(8'h10, 8'h00);
        u_host.wr(8'h11, 8'h00);
        @(negedge mclk);
        repeat (20)
        begin
            @(negedge mclk);
            seen = seen | t_exp;
        end
        chk({t_act, seen}, 2'h0);
    endtask
    // Mid-run reset with new strap levels; straps moving later must not reach the word.
    task automatic t_restrap;
        @(negedge mclk);
        rstn = 1'b0;
        s_rate = 4'h3;
        s_zpw = 1'b0;
        s_ref = 1'b1;
        s_mode = 2'h2;
        s_tpp = 2'h1;
        s_filt = 1'b1;
        s_gain = 2'h2;
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        repeat (2) @(negedge mclk);
        s_rate = 4'hF;
        rdc(8'h00, 32'h007F99A3);
        rdc(8'h10, 32'h0);
        chk({mei, zpw, rate}, 10'h093);
    endtask
    // Reset for three cycles, then every scenario.
    initial
    begin
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        rstn = 1'b1;
        repeat (2) @(negedge mclk);
        t_reset();
        t_aux();
        t_main();
        t_capture();
        t_timer();
        t_restrap();
        wrap_up();
    end
    // Watchdog at 5000 cycles, far beyond the roughly 140 cycles the scenarios need.
    initial
    begin
        #20000;
        error_cnt++;
        wrap_up();
    end
endmodule // icr_config_regs_tb
`default_nettype wire

// [test/icr_host_model.sv]
// Host model that programs the bank byte-wise and reads whole words.
`timescale 1ns/1ps
`default_nettype none
module icr_host_model
(
    input  wire logic        mclk,
    input  wire logic [31:0] reg_rdata_q,
    output logic             reg_wr,
    output logic [7:0]       reg_waddr,
    output logic [7:0]       reg_wdata,
    output logic             reg_rd,
    output logic [7:0]       reg_raddr
);
    // The bus idles with both strobes low.
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_waddr = 8'h00;
        reg_wdata = 8'h00;
        reg_raddr = 8'h00;
    end
    // Released data is inverted so the bank cannot lean on a held value.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_waddr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // Word write, lowest byte at the lowest address.
    task automatic wr32(input logic [7:0] a, input logic [31:0] v);
        for (int i = 0; i < 4; i++)
        begin
            wr(a + 8'(i), v[8*i +: 8]);
        end
    endtask
    // Word read; the answer is taken one edge after the request.
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(negedge mclk);
        reg_raddr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        v = reg_rdata_q;
    endtask
    // Error setup; the filter stays on so a gain range of 11 is legal, byte 1 is untouched.
    task automatic set_modes(input logic square);
        wr(8'h02, square ? 8'h7F : 8'h77);
        wr(8'h03, square ? 8'h40 : 8'h77);
    endtask
endmodule // icr_host_model
`default_nettype wire

// [verilog/icr_config_regs.v]
// Configuration register bank of the interpolator with read capture and timer.
// Notes on behaviour
// - Bit 10 is edge interval select MSB.
// - Index pulse one or four increments wide.
// - Bits 3..0 are rate, reset from straps.
// - Aux word read whole, written byte-wise.
// - Immediate capture ignores offset; else offset-shifted.
// - Timer period value plus one; zeros disable.
// - Disable bit stops gain and offset loops.
`timescale 1ns/1ps
`default_nettype none
`include "icr_map.vh"

module icr_config_regs
(
    input  wire        mclk,
    input  wire        rstn,
    input  wire        reg_wr,
    input  wire [7:0]  reg_waddr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_rd,
    input  wire [7:0]  reg_raddr,
    output reg  [31:0] reg_rdata_q,
    output reg         reg_rvalid_q,
    input  wire [3:0]  strap_rate,
    input  wire        strap_zpw,
    input  wire        strap_refdis,
    input  wire [1:0]  strap_mode,
    input  wire [1:0]  strap_tpp,
    input  wire        strap_filt,
    input  wire [1:0]  strap_gain,
    input  wire        capture_cmd,
    input  wire        sample_tick,
    input  wire [31:0] capture_src,
    output reg  [31:0] capture_hold_q,
    output reg         capture_done_q,
    input  wire [3:0]  prescale_tick,
    output wire        timer_expire_q,
    output wire        timer_active_q,
    output reg  [2:0]  min_edge_interval_q,
    output reg  [2:0]  zero_pulse_incr_q,
    output reg  [3:0]  interp_rate_q,
    output reg         gain_loop_run_q,
    output reg         offset_loop_run_q,
    output reg  [1:0]  amplitude_loop_settle_sel_q,
    output reg  [1:0]  offset_loop_settle_sel_q,
    output reg  [5:0]  phase_trim_value_q,
    output reg         phase_trim_range_sel_q
);

    reg  [31:0] main_config_word_q;
    reg  [31:0] aux_config_word_q;
    reg         straps_taken_q;
    reg         cap_armed_q;
    reg         cap_wait_q;
    reg  [4:0]  cap_cnt_q;
    wire [31:0] main_config_word_d;
    wire [31:0] aux_config_word_d;
    wire [31:0] strap_word;
    wire        immediate_read_capture;
    wire [4:0]  read_sync_offset;
    wire        main_hit;
    wire        aux_hit;
    wire [1:0]  lane;
    wire [3:0]  lane_sel;
    wire [31:0] aux_wmask;

    // Word decode on byte address bits 7..2 only; bits 1..0 pick the byte lane.
    assign main_hit  = reg_wr && ((reg_waddr & `ICR_WORD_MASK) == `ICR_MAIN_ADDR);
    assign aux_hit   = reg_wr && ((reg_waddr & `ICR_WORD_MASK) == `ICR_AUX_ADDR);
    assign lane      = reg_waddr[1:0];
    assign lane_sel  = 4'h1 << lane;
    assign aux_wmask = `ICR_AUX_WMASK;

    // Strap fields laid over the fixed reset value of the main word.
    assign strap_word = `ICR_MAIN_RESET
                      | ({28'h0000000, strap_rate} << `ICR_M_IR_LSB)
                      | ({31'h00000000, strap_zpw} << `ICR_M_ZPW_BIT)
                      | ({31'h00000000, strap_refdis} << `ICR_M_REFDIS_BIT)
                      | ({30'h00000000, strap_mode} << `ICR_M_MODE_LSB)
                      | ({30'h00000000, strap_tpp} << `ICR_M_TPP_LSB)
                      | ({31'h00000000, strap_filt} << `ICR_M_RSV_BIT)
                      | ({31'h00000000, strap_filt} << `ICR_M_DHE_BIT)
                      | ({30'h00000000, strap_gain} << `ICR_M_GAIN_LSB);

    ////////////////////////////////////////////////////////////////////////
    // Byte lanes: each write updates one byte, lowest byte at lowest address.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_lane
            assign main_config_word_d[gi*8 +: 8] =
                (main_hit && lane_sel[gi]) ? reg_wdata : main_config_word_q[gi*8 +: 8];
            assign aux_config_word_d[gi*8 +: 8] =
                ((aux_hit && lane_sel[gi]) ? reg_wdata : aux_config_word_q[gi*8 +: 8])
                & aux_wmask[gi*8 +: 8];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Register storage; straps are caught on the first edge after reset release,
    // since an asynchronous reset may only load constants.
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            main_config_word_q <= `ICR_MAIN_RESET;
            aux_config_word_q  <= `ICR_AUX_RESET;
            straps_taken_q     <= 1'b0;
        end
        else
        begin
            straps_taken_q <= 1'b1;
            if (!straps_taken_q)
            begin
                main_config_word_q <= strap_word;
            end
            else
            begin
                main_config_word_q <= main_config_word_d;
            end
            aux_config_word_q <= aux_config_word_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads answer one cycle later; unmapped addresses read zero.
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata_q  <= 32'h00000000;
            reg_rvalid_q <= 1'b0;
        end
        else
        begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd)
            begin
                if (reg_raddr == `ICR_AUX_ADDR)
                begin
                    reg_rdata_q <= aux_config_word_q;
                end
                else if (reg_raddr == `ICR_MAIN_ADDR)
                begin
                    reg_rdata_q <= main_config_word_q;
                end
                else
                begin
                    reg_rdata_q <= 32'h00000000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded configuration outputs, each held in a flip-flop.
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            min_edge_interval_q         <= 3'h0;
            zero_pulse_incr_q           <= `ICR_ZPW_NARROW;
            interp_rate_q               <= 4'h0;
            gain_loop_run_q             <= 1'b0;
            offset_loop_run_q           <= 1'b0;
            amplitude_loop_settle_sel_q <= 2'h0;
            offset_loop_settle_sel_q    <= 2'h0;
            phase_trim_value_q          <= 6'h00;
            phase_trim_range_sel_q      <= 1'b0;
        end
        else
        begin
            min_edge_interval_q <= main_config_word_q[`ICR_M_TPP_LSB +: 3];
            zero_pulse_incr_q   <= main_config_word_q[`ICR_M_ZPW_BIT] ?
                                   `ICR_ZPW_WIDE : `ICR_ZPW_NARROW;
            interp_rate_q       <= main_config_word_q[`ICR_M_IR_LSB +: 4];
            gain_loop_run_q     <= ~aux_config_word_q[`ICR_A_CORRECTION_LOOP_DISABLE_BIT];
            offset_loop_run_q   <= ~aux_config_word_q[`ICR_A_CORRECTION_LOOP_DISABLE_BIT];
            amplitude_loop_settle_sel_q <= aux_config_word_q[`ICR_A_GSET_LSB +: 2];
            offset_loop_settle_sel_q    <= aux_config_word_q[`ICR_A_OSET_LSB +: 2];
            phase_trim_value_q     <= aux_config_word_q[`ICR_A_PH_LSB +: 6];
            phase_trim_range_sel_q <= aux_config_word_q[`ICR_A_PHR_BIT];
        end
    end

    assign immediate_read_capture = aux_config_word_q[`ICR_A_IMMED_BIT];
    assign read_sync_offset       = aux_config_word_q[`ICR_A_SYNC_LSB +: 5];

    ////////////////////////////////////////////////////////////////////////
    // Read capture: immediate, or offset plus one clocks after the next sample tick.
    // A new command while one is pending restarts the wait; the older one is dropped.
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            capture_hold_q <= 32'h00000000;
            capture_done_q <= 1'b0;
            cap_armed_q    <= 1'b0;
            cap_wait_q     <= 1'b0;
            cap_cnt_q      <= 5'h00;
        end
        else
        begin
            capture_done_q <= 1'b0;
            if (capture_cmd && immediate_read_capture)
            begin
                capture_hold_q <= capture_src;
                capture_done_q <= 1'b1;
                cap_armed_q    <= 1'b0;
                cap_wait_q     <= 1'b0;
            end
            else if (capture_cmd)
            begin
                cap_armed_q <= 1'b1;
                cap_wait_q  <= 1'b0;
            end
            else if (cap_armed_q && sample_tick)
            begin
                cap_armed_q <= 1'b0;
                cap_wait_q  <= 1'b1;
                cap_cnt_q   <= read_sync_offset;
            end
            else if (cap_wait_q)
            begin
                if (cap_cnt_q == 5'h00)
                begin
                    capture_hold_q <= capture_src;
                    capture_done_q <= 1'b1;
                    cap_wait_q     <= 1'b0;
                end
                else
                begin
                    cap_cnt_q <= cap_cnt_q - 5'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer driven by the aux word's prescale and value fields.
    icr_timer u_timer
    (
        .mclk          (mclk),
        .rstn          (rstn),
        .prescale_sel  (aux_config_word_q[`ICR_A_PRESC_LSB +: 2]),
        .timer_value   (aux_config_word_q[`ICR_A_TIMER_LSB +: 8]),
        .prescale_tick (prescale_tick),
        .expire_q      (timer_expire_q),
        .active_q      (timer_active_q)
    );

endmodule // icr_config_regs

`default_nettype wire

// [verilog/icr_map.vh]
// Register offsets, field positions and reset values of the interpolator configuration bank.
`ifndef ICR_MAP_VH
`define ICR_MAP_VH

// Byte addresses of the two configuration words.
`define ICR_MAIN_ADDR        8'h00
`define ICR_AUX_ADDR         8'h10
`define ICR_WORD_MASK        8'hFC

// Fields of the main configuration word.
`define ICR_M_IR_LSB         0
`define ICR_M_ZPW_BIT        4
`define ICR_M_REFDIS_BIT     5
`define ICR_M_MODE_LSB       6
`define ICR_M_TPP_LSB        8
`define ICR_M_TPP_MSB_BIT    10
`define ICR_M_RSV_BIT        11
`define ICR_M_DHE_BIT        12
`define ICR_M_GAIN_LSB       14

// Fixed reset value of the main word; strap fields are merged in after reset release.
`define ICR_MAIN_RESET       32'h007F0000
`define ICR_AUX_RESET        32'h00000000

// Fields of the aux configuration word.
`define ICR_A_TIMER_LSB      0
`define ICR_A_PRESC_LSB      8
`define ICR_A_SYNC_LSB       10
`define ICR_A_IMMED_BIT      15
`define ICR_A_CORRECTION_LOOP_DISABLE_BIT     16
`define ICR_A_GSET_LSB       17
`define ICR_A_OSET_LSB       19
`define ICR_A_PH_LSB         24
`define ICR_A_PHR_BIT        30
`define ICR_AUX_WMASK        32'h7F1FFFFF

// Index pulse widths in increments.
`define ICR_ZPW_NARROW       3'h1
`define ICR_ZPW_WIDE         3'h4

`endif

// [verilog/icr_timer.v]
// Programmable timer: period is (value + 1) prescaler ticks.
`timescale 1ns/1ps
`default_nettype none

module icr_timer
(
    input  wire        mclk,
    input  wire        rstn,
    input  wire [1:0]  prescale_sel,
    input  wire [7:0]  timer_value,
    input  wire [3:0]  prescale_tick,
    output reg         expire_q,
    output reg         active_q
);

    reg  [7:0] cnt_q;
    wire       enable;
    wire       tick;

    // Both fields at zero park the timer.
    assign enable = (prescale_sel != 2'h0) || (timer_value != 8'h00);
    assign tick   = prescale_tick[prescale_sel];

    ////////////////////////////////////////////////////////////////////////
    // Count prescaler ticks; the count restarts after value + 1 ticks.
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_q    <= 8'h00;
            expire_q <= 1'b0;
            active_q <= 1'b0;
        end
        else
        begin
            active_q <= enable;
            expire_q <= 1'b0;
            if (!enable)
            begin
                cnt_q <= 8'h00;
            end
            else if (tick)
            begin
                if (cnt_q >= timer_value)
                begin
                    cnt_q    <= 8'h00;
                    expire_q <= 1'b1;
                end
                else
                begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end

endmodule // icr_timer

`default_nettype wire
